/* verilog/ppc_pin_cfg.sv */
// Purpose: Pin drive, pull and edge interrupt configuration for ports M, P, H, J, AD1 and bus ports.
// Assumes: Avalon-MM slave with waitrequest; pin levels are asynchronous to ref_clk.
// Notes:   Every access takes one wait cycle; flags clear by writing ones.
//
// Functional notes
// - Falling polarity selected: a falling port P edge sets that pin's flag.
// - Rising polarity selected: a rising port P edge sets that pin's flag.
// - Falling polarity pulls up, rising pulls down, only with pull enable and input.
// - Per-pin port P enable: 0 masks the flag, 1 lets it request.
// - Port M drive bits pick full or one-sixth drive; ignored for inputs.
// - Port M pull enable acts for inputs or wired-OR outputs, not push-pull.
// - Port M pull enables are all off after reset.
// - Analog upper-byte drive bits reduce drive of outputs only.
// - Analog top pull-ups act only for inputs and are off after reset.
// - Bus drive bits 7, 4, 1, 0 reduce ports K, E, B, A.
// - Port-wide reduced drive applies whatever function owns the pin.
// - Emulation mode disables port-wide reduced drive on bus ports.
// - Implemented bits without drive function still store and read back.
// - All eight port H pins detect edge interrupts.
// - Port J pins 7 to 4 and 2 to 0 detect edge interrupts.
// - Serial two-wire precedence turns port J pins open-drain.
// - Flag and enable both set raise the port request and wake.
// - All pins of a port share one request; direction does not matter.
`timescale 1ns/10ps
`default_nettype none
module ppc_pin_cfg (
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic [7:0]        address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  input  wire ppc_pkg::ppc_pins_t pins_i,
  input  wire ppc_pkg::ppc_dir_t  dir_i,
  output ppc_pkg::ppc_pad_t       pad_o
);
  import ppc_pkg::*;

  ppc_state_t st_r;
  ppc_state_t st_nxt;
  logic       req;
  logic       taken;
  logic [7:0] wd;
  logic [7:0] clr_p;
  logic [7:0] clr_h;
  logic [7:0] clr_j;
  logic [7:0] rsel;

  // Polarity 1 catches rising edges, 0 falling edges.
  function automatic logic [7:0] edge_hit(input logic [7:0] prv,
                                          input logic [7:0] cur,
                                          input logic [7:0] pol);
    return (pol & cur & ~prv) | (~pol & prv & ~cur);
  endfunction

  assign req         = read | write;
  assign waitrequest = req & ~st_r.ack;
  assign taken       = req & st_r.ack;
  assign wd          = writedata[7:0];
  assign readdata    = st_r.rdata;
  assign pad_o       = st_r.pad;

  always_comb begin
    st_nxt = st_r;
    clr_p  = 8'h00;
    clr_h  = 8'h00;
    clr_j  = 8'h00;
    rsel   = 8'h00;

    st_nxt.ack = req & ~st_r.ack;

    // The first stage feeds only the second; edges compare stage two with its
    // previous value, so a metastable sample never reaches the flags.
    st_nxt.s1   = pins_i;
    st_nxt.s2   = st_r.s1;
    st_nxt.prev = st_r.s2;

    if (write && taken && byteenable[0]) begin
      if (address == OFS_M_DRIVE) begin
        st_nxt.m_rdr = wd;
      end else if (address == OFS_M_PULL) begin
        st_nxt.m_pull = wd;
      end else if (address == OFS_P_POL) begin
        st_nxt.p_pol = wd;
      end else if (address == OFS_P_IEN) begin
        st_nxt.p_en = wd;
      end else if (address == OFS_P_FLAGS) begin
        clr_p = wd;
      end else if (address == OFS_P_PULL) begin
        st_nxt.p_pull = wd;
      end else if (address == OFS_AD_DRIVE) begin
        st_nxt.ad_rdr = wd;
      end else if (address == OFS_AD_PULLUP) begin
        st_nxt.ad_pu = wd;
      end else if (address == OFS_BUS_DRIVE) begin
        st_nxt.ebi = wd;
      end else if (address == OFS_H_POL) begin
        st_nxt.h_pol = wd;
      end else if (address == OFS_H_IEN) begin
        st_nxt.h_en = wd;
      end else if (address == OFS_H_FLAGS) begin
        clr_h = wd;
      end else if (address == OFS_J_POL) begin
        st_nxt.j_pol = wd & PORT_J_MASK;
      end else if (address == OFS_J_IEN) begin
        st_nxt.j_en = wd & PORT_J_MASK;
      end else if (address == OFS_J_FLAGS) begin
        clr_j = wd;
      end
    end

    // A new edge in the clearing cycle survives: the set term is ORed last.
    st_nxt.p_flg = (st_r.p_flg & ~clr_p)
                 | edge_hit(st_r.prev.p, st_r.s2.p, st_r.p_pol);
    st_nxt.h_flg = (st_r.h_flg & ~clr_h)
                 | edge_hit(st_r.prev.h, st_r.s2.h, st_r.h_pol);
    st_nxt.j_flg = (st_r.j_flg & ~clr_j)
                 | (edge_hit(st_r.prev.j, st_r.s2.j, st_r.j_pol)
                    & PORT_J_MASK);

    if (read && !st_r.ack) begin
      if (address == OFS_M_DRIVE) begin
        rsel = st_r.m_rdr;
      end else if (address == OFS_M_PULL) begin
        rsel = st_r.m_pull;
      end else if (address == OFS_P_POL) begin
        rsel = st_r.p_pol;
      end else if (address == OFS_P_IEN) begin
        rsel = st_r.p_en;
      end else if (address == OFS_P_FLAGS) begin
        rsel = st_r.p_flg;
      end else if (address == OFS_P_PULL) begin
        rsel = st_r.p_pull;
      end else if (address == OFS_AD_DRIVE) begin
        rsel = st_r.ad_rdr;
      end else if (address == OFS_AD_PULLUP) begin
        rsel = st_r.ad_pu;
      end else if (address == OFS_BUS_DRIVE) begin
        rsel = st_r.ebi;
      end else if (address == OFS_H_POL) begin
        rsel = st_r.h_pol;
      end else if (address == OFS_H_IEN) begin
        rsel = st_r.h_en;
      end else if (address == OFS_H_FLAGS) begin
        rsel = st_r.h_flg;
      end else if (address == OFS_J_POL) begin
        rsel = st_r.j_pol;
      end else if (address == OFS_J_IEN) begin
        rsel = st_r.j_en;
      end else if (address == OFS_J_FLAGS) begin
        rsel = st_r.j_flg;
      end
      st_nxt.rdata = {24'h000000, rsel};
    end

    st_nxt.pad.m_rdrive = st_nxt.m_rdr & dir_i.m_out;
    st_nxt.pad.m_pull   = st_nxt.m_pull & (~dir_i.m_out | dir_i.m_wor);
    st_nxt.pad.p_pull_up = st_nxt.p_pull & ~dir_i.p_out & ~st_nxt.p_pol;
    st_nxt.pad.p_pull_dn = st_nxt.p_pull & ~dir_i.p_out & st_nxt.p_pol;
    st_nxt.pad.ad_hi_rdrive  = st_nxt.ad_rdr & dir_i.ad_hi_out;
    st_nxt.pad.ad_top_pullup = st_nxt.ad_pu & ~dir_i.ad_top_out;
    st_nxt.pad.j_odrain = dir_i.j_iic & PORT_J_MASK;

    // Bus port drive ignores pin ownership and direction on purpose.
    st_nxt.pad.bus_rdrive = {st_nxt.ebi[BUS_K_BIT], st_nxt.ebi[BUS_E_BIT],
                             st_nxt.ebi[BUS_B_BIT], st_nxt.ebi[BUS_A_BIT]}
                          & {4{~dir_i.emul}};

    st_nxt.pad.irq_p = |(st_nxt.p_flg & st_nxt.p_en);
    st_nxt.pad.irq_h = |(st_nxt.h_flg & st_nxt.h_en);
    st_nxt.pad.irq_j = |(st_nxt.j_flg & st_nxt.j_en);
    st_nxt.pad.wake  = st_nxt.pad.irq_p | st_nxt.pad.irq_h
                     | st_nxt.pad.irq_j;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_r        <= '0;
      st_r.m_pull <= REG_RST;
      st_r.ad_pu  <= REG_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Checks.
  logic [7:0] p_fall;
  logic [7:0] p_rise;
  logic [7:0] h_hit;
  logic [7:0] j_hit;

  assign p_fall = st_r.prev.p & ~st_r.s2.p & ~st_r.p_pol;
  assign p_rise = ~st_r.prev.p & st_r.s2.p & st_r.p_pol;

  // Written out again here rather than through the function, so a slip in the
  // function cannot hide itself from the checks.
  assign h_hit = (st_r.h_pol & st_r.s2.h & ~st_r.prev.h)
               | (~st_r.h_pol & st_r.prev.h & ~st_r.s2.h);
  assign j_hit = ((st_r.j_pol & st_r.s2.j & ~st_r.prev.j)
               | (~st_r.j_pol & st_r.prev.j & ~st_r.s2.j)) & PORT_J_MASK;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  property p_fall_flag;
    p_fall != 8'h00 |=> (st_r.p_flg & $past(p_fall)) == $past(p_fall);
  endproperty
  a_fall_flag: assert property (p_fall_flag) else $error("falling edge lost");

  property p_rise_flag;
    p_rise != 8'h00 |=> (st_r.p_flg & $past(p_rise)) == $past(p_rise);
  endproperty
  a_rise_flag: assert property (p_rise_flag) else $error("rising edge lost");

  property p_pull_dir;
    ((pad_o.p_pull_up & st_r.p_pol) == 8'h00)
    && ((pad_o.p_pull_dn & ~st_r.p_pol) == 8'h00);
  endproperty
  a_pull_dir: assert property (p_pull_dir) else $error("pull direction wrong");

  property p_irq_p;
    pad_o.irq_p == |(st_r.p_flg & st_r.p_en);
  endproperty
  a_irq_p: assert property (p_irq_p) else $error("port P request wrong");

  property p_m_drive_in;
    1'b1 |=> (pad_o.m_rdrive & ~$past(dir_i.m_out)) == 8'h00;
  endproperty
  a_m_drive_in: assert property (p_m_drive_in) else $error("reduced input drive");

  property p_ad_pullup;
    1'b1 |=> (pad_o.ad_top_pullup & $past(dir_i.ad_top_out)) == 8'h00;
  endproperty
  a_ad_pullup: assert property (p_ad_pullup) else $error("pull-up on output");

  property p_emul;
    dir_i.emul |=> pad_o.bus_rdrive == 4'h0;
  endproperty
  a_emul: assert property (p_emul) else $error("reduced drive in emulation");

  property p_bus_store;
    write && !waitrequest && byteenable[0] && address == OFS_BUS_DRIVE
      |=> st_r.ebi == $past(writedata[7:0]);
  endproperty
  a_bus_store: assert property (p_bus_store) else $error("bus drive not stored");

  property p_odrain;
    1'b1 |=> pad_o.j_odrain == ($past(dir_i.j_iic) & PORT_J_MASK);
  endproperty
  a_odrain: assert property (p_odrain) else $error("open-drain select wrong");

  property p_wake;
    pad_o.wake == (pad_o.irq_p | pad_o.irq_h | pad_o.irq_j);
  endproperty
  a_wake: assert property (p_wake) else $error("wake mismatch");

  property p_one_wait;
    req && waitrequest |=> !waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("bus answer late");

  // A fresh request always sees one wait cycle first.
  property p_wait_first;
    (read || write) && !$past(read || write) |-> waitrequest;
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("bus answer early");

  property p_h_flag;
    h_hit != 8'h00 |=> (st_r.h_flg & $past(h_hit)) == $past(h_hit);
  endproperty
  a_h_flag: assert property (p_h_flag) else $error("port H edge lost");

  property p_j_flag;
    j_hit != 8'h00 |=> (st_r.j_flg & $past(j_hit)) == $past(j_hit);
  endproperty
  a_j_flag: assert property (p_j_flag) else $error("port J edge lost");

  // Port J bit 3 has no pin, so nothing behind it may ever hold a one.
  property p_j_bit3;
    !st_r.j_flg[3] && !st_r.j_pol[3] && !st_r.j_en[3];
  endproperty
  a_j_bit3: assert property (p_j_bit3) else $error("port J bit 3 set");

  property p_irq_h;
    pad_o.irq_h == |(st_r.h_flg & st_r.h_en);
  endproperty
  a_irq_h: assert property (p_irq_h) else $error("port H request wrong");

  property p_irq_j;
    pad_o.irq_j == |(st_r.j_flg & st_r.j_en);
  endproperty
  a_irq_j: assert property (p_irq_j) else $error("port J request wrong");

  property p_wake_p;
    pad_o.irq_p |-> pad_o.wake;
  endproperty
  a_wake_p: assert property (p_wake_p) else $error("no wake on request");

  // Flags only ever drop through a write to their own clear register.
  property p_hold_p;
    !(write && taken && byteenable[0] && address == OFS_P_FLAGS)
      |=> (st_r.p_flg & $past(st_r.p_flg)) == $past(st_r.p_flg);
  endproperty
  a_hold_p: assert property (p_hold_p) else $error("port P flag dropped");

  property p_hold_h;
    !(write && taken && byteenable[0] && address == OFS_H_FLAGS)
      |=> (st_r.h_flg & $past(st_r.h_flg)) == $past(st_r.h_flg);
  endproperty
  a_hold_h: assert property (p_hold_h) else $error("port H flag dropped");

  property p_hold_j;
    !(write && taken && byteenable[0] && address == OFS_J_FLAGS)
      |=> (st_r.j_flg & $past(st_r.j_flg)) == $past(st_r.j_flg);
  endproperty
  a_hold_j: assert property (p_hold_j) else $error("port J flag dropped");

  property p_m_pull_pp;
    1'b1 |=> (pad_o.m_pull & $past(dir_i.m_out & ~dir_i.m_wor)) == 8'h00;
  endproperty
  a_m_pull_pp: assert property (p_m_pull_pp) else $error("pull on push-pull");

  property p_ad_drive_in;
    1'b1 |=> (pad_o.ad_hi_rdrive & ~$past(dir_i.ad_hi_out)) == 8'h00;
  endproperty
  a_ad_drive_in: assert property (p_ad_drive_in) else $error("reduced AD input");

  property p_p_pull_out;
    1'b1 |=> ((pad_o.p_pull_up | pad_o.p_pull_dn) & $past(dir_i.p_out)) == 8'h00;
  endproperty
  a_p_pull_out: assert property (p_p_pull_out) else $error("pull on P output");

  property p_pull_excl;
    (pad_o.p_pull_up & pad_o.p_pull_dn) == 8'h00;
  endproperty
  a_pull_excl: assert property (p_pull_excl) else $error("both pulls on");

  // Outside emulation each bus port follows its own stored bit.
  property p_bus_map;
    !dir_i.emul |=> pad_o.bus_rdrive == {st_r.ebi[BUS_K_BIT], st_r.ebi[BUS_E_BIT],
                                         st_r.ebi[BUS_B_BIT], st_r.ebi[BUS_A_BIT]};
  endproperty
  a_bus_map: assert property (p_bus_map) else $error("bus drive map wrong");

  property p_read_upper;
    readdata[31:8] == 24'h000000;
  endproperty
  a_read_upper: assert property (p_read_upper) else $error("read upper bits set");

  c_rise_irq: cover property (p_rise != 8'h00 ##1 pad_o.irq_p);
  c_fall_flag: cover property (p_fall != 8'h00);
  c_emul: cover property (dir_i.emul && st_r.ebi != 8'h00);
  c_flag_clr: cover property (st_r.p_flg != 8'h00 ##1 st_r.p_flg == 8'h00);
  c_j_irq: cover property (j_hit != 8'h00 ##1 pad_o.irq_j);

endmodule
`default_nettype wire

/* verilog/ppc_pkg.sv */
// Purpose: Shared constants and carrier types for the port pin configuration block.
// Assumes: Registers sit one per aligned 32-bit word; data lives in bits 7:0.
// Notes:   All register reset values are zero, so every pull device starts off.
`default_nettype none
package ppc_pkg;

  localparam logic [7:0] OFS_M_DRIVE   = 8'h00;
  localparam logic [7:0] OFS_M_PULL    = 8'h04;
  localparam logic [7:0] OFS_P_POL     = 8'h08;
  localparam logic [7:0] OFS_P_IEN     = 8'h0c;
  localparam logic [7:0] OFS_P_FLAGS   = 8'h10;
  localparam logic [7:0] OFS_P_PULL    = 8'h14;
  localparam logic [7:0] OFS_AD_DRIVE  = 8'h18;
  localparam logic [7:0] OFS_AD_PULLUP = 8'h1c;
  localparam logic [7:0] OFS_BUS_DRIVE = 8'h20;
  localparam logic [7:0] OFS_H_POL     = 8'h24;
  localparam logic [7:0] OFS_H_IEN     = 8'h28;
  localparam logic [7:0] OFS_H_FLAGS   = 8'h2c;
  localparam logic [7:0] OFS_J_POL     = 8'h30;
  localparam logic [7:0] OFS_J_IEN     = 8'h34;
  localparam logic [7:0] OFS_J_FLAGS   = 8'h38;

  localparam logic [7:0] REG_RST       = 8'h00;
  localparam logic [7:0] PORT_J_MASK   = 8'hf7;

  localparam int BUS_K_BIT = 7;
  localparam int BUS_E_BIT = 4;
  localparam int BUS_B_BIT = 1;
  localparam int BUS_A_BIT = 0;

  typedef struct packed {
    logic [7:0] p;
    logic [7:0] h;
    logic [7:0] j;
  } ppc_pins_t;

  typedef struct packed {
    logic [7:0] m_out;
    logic [7:0] m_wor;
    logic [7:0] p_out;
    logic [7:0] ad_hi_out;
    logic [7:0] ad_top_out;
    logic [7:0] j_iic;
    logic       emul;
  } ppc_dir_t;

  typedef struct packed {
    logic [7:0] m_rdrive;
    logic [7:0] m_pull;
    logic [7:0] p_pull_up;
    logic [7:0] p_pull_dn;
    logic [7:0] ad_hi_rdrive;
    logic [7:0] ad_top_pullup;
    logic [7:0] j_odrain;
    logic [3:0] bus_rdrive;
    logic       irq_p;
    logic       irq_h;
    logic       irq_j;
    logic       wake;
  } ppc_pad_t;

  typedef struct packed {
    logic [7:0]  m_rdr;
    logic [7:0]  m_pull;
    logic [7:0]  p_pol;
    logic [7:0]  p_en;
    logic [7:0]  p_flg;
    logic [7:0]  p_pull;
    logic [7:0]  ad_rdr;
    logic [7:0]  ad_pu;
    logic [7:0]  ebi;
    logic [7:0]  h_pol;
    logic [7:0]  h_en;
    logic [7:0]  h_flg;
    logic [7:0]  j_pol;
    logic [7:0]  j_en;
    logic [7:0]  j_flg;
    ppc_pins_t   s1;
    ppc_pins_t   s2;
    ppc_pins_t   prev;
    ppc_pad_t    pad;
    logic        ack;
    logic [31:0] rdata;
  } ppc_state_t;

endpackage
`default_nettype wire

/* verification/ppc_board.sv */
// Purpose: Board-side model of the port pins seen by the pin configuration block.
// Assumes: The bench sets the level it wants on each pin just after a clock edge.
// Notes:   A released port P pin follows the selected pull, or wanders when none is on.
`timescale 1ns/10ps
`default_nettype none
module ppc_board (
  input  wire logic               ref_clk,
  input  wire ppc_pkg::ppc_pins_t drv,
  input  wire logic [7:0]         p_oe,
  input  wire ppc_pkg::ppc_pad_t  pad,
  output ppc_pkg::ppc_pins_t      pins
);
  import ppc_pkg::*;

  logic [7:0] flt_r = 8'h00;

  // An unpulled, undriven pin must not look stable, so it toggles every cycle.
  always_ff @(posedge ref_clk) begin
    flt_r <= ~flt_r;
  end

  always_comb begin
    pins = drv;
    for (int i = 0; i < 8; i++) begin
      if (!p_oe[i]) begin
        pins.p[i] = pad.p_pull_up[i] ? 1'b1 : (pad.p_pull_dn[i] ? 1'b0 : flt_r[i]);
      end
    end
  end
endmodule
`default_nettype wire

/* verification/port_pin_config_and_edge_irq_test.sv */
// Purpose: Self-checking bench for the port pin configuration and edge interrupt block.
// Assumes: One wait cycle per bus access as the slave promises, but waits are bounded.
// Notes:   Flags are cleared by writing ones before each port's edge sequence.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin mismatches++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module port_pin_config_and_edge_irq_test;
  import ppc_pkg::*;

  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  address = 8'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0]  byteenable = 4'h1;
  logic [31:0] readdata;
  logic        waitrequest;
  ppc_pins_t   pins;
  ppc_pins_t   drv = '0;
  ppc_dir_t    dir = '0;
  ppc_pad_t    pad;
  logic [7:0]  q;
  int          mismatches = 0;
  int          samples_checked = 0;

  always #5 ref_clk = ~ref_clk;

  ppc_pin_cfg dut (.ref_clk(ref_clk), .resetn(resetn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .pins_i(pins), .dir_i(dir), .pad_o(pad));
  ppc_board board (.ref_clk(ref_clk), .drv(drv), .p_oe(8'hff), .pad(pad), .pins(pins));

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // The request is held until waitrequest is seen low at a rising edge.
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] r);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    address <= a;
    write <= w;
    read <= !w;
    writedata <= {24'h0, d};
    // Both values are read mid-cycle, where they stand for the coming rising edge,
    // so the design's own update at that edge cannot race the look.
    while (!done) begin
      @(negedge ref_clk);
      done = (waitrequest === 1'b0);
      r = readdata[7:0];
      @(posedge ref_clk);
      n++;
      if (!done && n > 20) begin
        mismatches++;
        close_out();
      end
    end
    read <= 1'b0;
    write <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic reset_vals;
    `CHK(pad, '0);
    for (int i = 0; i < 15; i++) begin
      bus(1'b0, 8'(i * 4), 8'h00, q);
      `CHK(q, 8'h00);
    end
  endtask

  task automatic readback;
    for (int i = 0; i < 9; i++) begin
      wr(8'(i * 4), 8'ha5 ^ 8'(i));
      bus(1'b0, 8'(i * 4), 8'h00, q);
      // The port P flag register clears on ones, so it reads back empty.
      `CHK(q, (i == 4) ? 8'h00 : (8'ha5 ^ 8'(i)));
    end
    byteenable <= 4'h0;
    wr(OFS_M_DRIVE, 8'hff);
    byteenable <= 4'h1;
    bus(1'b0, OFS_M_DRIVE, 8'h00, q);
    `CHK(q, 8'ha5);
    wr(OFS_J_POL, 8'hff);
    bus(1'b0, OFS_J_POL, 8'h00, q);
    `CHK(q, 8'hf7);
    wr(8'h40, 8'hff);
    bus(1'b0, 8'h40, 8'h00, q);
    `CHK(q, 8'h00);
  endtask

  task automatic cfg_outputs;
    dir.m_out <= 8'hf0;
    dir.m_wor <= 8'h30;
    dir.p_out <= 8'h3c;
    dir.ad_hi_out <= 8'ha5;
    dir.ad_top_out <= 8'h5a;
    dir.j_iic <= 8'hff;
    wr(OFS_M_DRIVE, 8'hff);
    wr(OFS_M_PULL, 8'hff);
    wr(OFS_P_POL, 8'h0f);
    wr(OFS_P_PULL, 8'hff);
    wr(OFS_AD_DRIVE, 8'hff);
    wr(OFS_AD_PULLUP, 8'hff);
    wr(OFS_BUS_DRIVE, 8'hff);
    cyc(3);
    `CHK(pad.m_rdrive, 8'hf0);
    `CHK(pad.m_pull, 8'h3f);
    `CHK(pad.p_pull_up, 8'hc0);
    `CHK(pad.p_pull_dn, 8'h03);
    `CHK(pad.ad_hi_rdrive, 8'ha5);
    `CHK(pad.ad_top_pullup, 8'ha5);
    `CHK(pad.bus_rdrive, 4'hf);
    `CHK(pad.j_odrain, 8'hf7);
    wr(OFS_BUS_DRIVE, 8'h92);
    cyc(3);
    `CHK(pad.bus_rdrive, 4'he);
    dir.emul <= 1'b1;
    cyc(3);
    `CHK(pad.bus_rdrive, 4'h0);
    dir.emul <= 1'b0;
  endtask

  task automatic set_port(input int k, input logic [7:0] v);
    case (k)
      0: drv.p <= v;
      1: drv.h <= v;
      default: drv.j <= v;
    endcase
  endtask

  function automatic logic irq_of(input int k);
    return (k == 0) ? pad.irq_p : ((k == 1) ? pad.irq_h : pad.irq_j);
  endfunction

  // Pins 3:0 watch rising edges, 7:4 falling; only pin 0 may request.
  task automatic port_edges(input int k, input logic [7:0] b, input logic [7:0] m);
    set_port(k, 8'h00);
    wr(b, 8'h0f);
    wr(b + 8'h04, 8'h01);
    cyc(4);
    wr(b + 8'h08, 8'hff);
    set_port(k, 8'hff);
    cyc(6);
    bus(1'b0, b + 8'h08, 8'h00, q);
    `CHK(q, 8'h0f & m);
    `CHK(irq_of(k), 1'b1);
    `CHK(pad.wake, 1'b1);
    set_port(k, 8'h00);
    cyc(6);
    bus(1'b0, b + 8'h08, 8'h00, q);
    `CHK(q, m);
    wr(b + 8'h04, 8'h00);
    cyc(3);
    `CHK(irq_of(k), 1'b0);
    wr(b + 8'h08, 8'hff);
    bus(1'b0, b + 8'h08, 8'h00, q);
    `CHK(q, 8'h00);
  endtask

  initial begin
    repeat (100000) @(posedge ref_clk);
    mismatches++;
    close_out();
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    reset_vals();
    readback();
    cfg_outputs();
    port_edges(0, OFS_P_POL, 8'hff);
    port_edges(1, OFS_H_POL, 8'hff);
    port_edges(2, OFS_J_POL, 8'hf7);
    close_out();
  end
endmodule
`default_nettype wire
